// ==== cmc_top.sv ====
/*
  can mode control register block with mode change arbitration and abort logic.
  assumes a strobe register port (read data one cycle later) and a can rx pin.
*/
// Operation
// - When idle stop is set the controller halts while the device is in idle, otherwise it runs on.
// - Writing one to abort all tx aborts every pending transmission and the bit self-clears when done.
// - The requested mode field takes codes 0,1,2,3,4,7 and software never writes 5 or 6.
// - The current mode field reports the mode in effect using the same codes.
// - With capture enabled each received message gives one capture pulse, otherwise none.
// - The window select bit picks filter registers when one and buffer registers when zero.
// - A mode change is taken only after at least 11 recessive bits of idle bus.
// - A transmission waiting out the idle period when disable is requested is aborted and flagged.
`timescale 1ns/100ps
module cmc_top
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        can_rx,
    input  wire logic        device_idle,
    input  wire logic        rx_msg_done,
    input  wire logic        tx_pending,
    input  wire logic        tx_waiting_idle,
    input  wire logic        tx_all_aborted,
    output logic             ctl_running,
    output logic             abort_req,
    output logic             tx_aborted_flag,
    output logic             tx_request_clear,
    output logic             capture_event,
    output logic             filter_window,
    output logic      [2:0]  mode_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        idle_stop;
    logic        abort_all_tx;
    logic [2:0]  requested_mode;
    logic [2:0]  current_mode;
    logic        rx_capture_enable;
    logic        map_window_select;
    logic [15:0] bit_div;
    logic [15:0] div_cnt;
    logic        rx_sync;
    logic        tx_abort_sticky;
    logic [15:0] ctrl_word;
    logic        ctrl_wr;
    logic        disable_now;

    cmc_bus_if bus ();

    cmc_sync i_cmc_sync
    (
        .clk   (clk),
        .reset (reset),
        .din   (can_rx),
        .dout  (rx_sync)
    );

    cmc_idle_det i_cmc_idle_det
    (
        .clk   (clk),
        .reset (reset),
        .bus   (bus)
    );

    assign bus.rx_level = rx_sync;
    assign ctrl_wr      = wr && addr == cmc_pkg::ADDR_CTRL;

    // ------------------------------------------------------------
    // bit time tick
    // ------------------------------------------------------------
    // a divisor written below the running count reloads at once instead of wrapping
    always_ff @(posedge clk)
    begin
        if (reset || div_cnt >= bit_div)
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    assign bus.bit_tick = (div_cnt >= bit_div);

    always_ff @(posedge clk)
    begin
        if (reset)
            bit_div <= cmc_pkg::BITDIV_RESET;
        else if (wr && addr == cmc_pkg::ADDR_BITDIV)
            bit_div <= wdata;
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            idle_stop         <= 1'b0;
            rx_capture_enable <= 1'b0;
            map_window_select <= 1'b0;
            requested_mode    <= cmc_pkg::MODE_CONFIG;
        end
        else if (ctrl_wr)
        begin
            idle_stop         <= wdata[cmc_pkg::POS_IDLE_STOP];
            rx_capture_enable <= wdata[cmc_pkg::POS_CAPTURE];
            map_window_select <= wdata[cmc_pkg::POS_WINDOW];
            requested_mode    <= wdata[cmc_pkg::POS_REQ_LO +: 3];
        end
    end

    // set by write, cleared by hardware when all aborted; a fresh write wins
    always_ff @(posedge clk)
    begin
        if (reset)
            abort_all_tx <= 1'b0;
        else if (ctrl_wr && wdata[cmc_pkg::POS_ABORT])
            abort_all_tx <= 1'b1;
        else if (abort_all_tx && tx_all_aborted)
            abort_all_tx <= 1'b0;
    end

    assign abort_req = abort_all_tx;

    // ------------------------------------------------------------
    // mode change
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            current_mode <= cmc_pkg::MODE_CONFIG;
        else if (requested_mode != current_mode && bus.bus_idle
                 && !(requested_mode == cmc_pkg::MODE_CONFIG && tx_pending
                      && !tx_waiting_idle))
            current_mode <= requested_mode;
    end

    assign mode_out = current_mode;

    // disable requested while a transmission waits out the idle period
    assign disable_now = requested_mode == cmc_pkg::MODE_DISABLE
                         && current_mode != cmc_pkg::MODE_DISABLE && tx_waiting_idle;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tx_aborted_flag  <= 1'b0;
            tx_request_clear <= 1'b0;
        end
        else
        begin
            tx_aborted_flag  <= disable_now;
            tx_request_clear <= disable_now;
        end
    end

    // status sticky: set wins over a clearing write
    always_ff @(posedge clk)
    begin
        if (reset)
            tx_abort_sticky <= 1'b0;
        else if (disable_now)
            tx_abort_sticky <= 1'b1;
        else if (wr && addr == cmc_pkg::ADDR_STATUS && wdata[0])
            tx_abort_sticky <= 1'b0;
    end

    // ------------------------------------------------------------
    // run, capture and window outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            ctl_running <= 1'b1;
        else
            ctl_running <= !(idle_stop && device_idle);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            capture_event <= 1'b0;
        else
            capture_event <= rx_capture_enable && rx_msg_done;
    end

    assign filter_window = map_window_select;

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_word                                = 16'h0000;
        ctrl_word[cmc_pkg::POS_IDLE_STOP]        = idle_stop;
        ctrl_word[cmc_pkg::POS_ABORT]            = abort_all_tx;
        ctrl_word[cmc_pkg::POS_REQ_LO +: 3]      = requested_mode;
        ctrl_word[cmc_pkg::POS_CUR_LO +: 3]      = current_mode;
        ctrl_word[cmc_pkg::POS_CAPTURE]          = rx_capture_enable;
        ctrl_word[cmc_pkg::POS_WINDOW]           = map_window_select;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= 16'h0000;
        else if (rd)
        begin
            case (addr)
                cmc_pkg::ADDR_CTRL:   rdata <= ctrl_word;
                cmc_pkg::ADDR_STATUS: rdata <= {14'h0000, bus.bus_idle, tx_abort_sticky};
                cmc_pkg::ADDR_BITDIV: rdata <= bit_div;
                default:              rdata <= 16'h0000;
            endcase
        end
        else
            rdata <= 16'h0000;
    end
endmodule : cmc_top

// ==== cmc_pkg.sv ====
/*
  package for the can mode control block: register layout, mode codes, timing.
  assumes a 16-bit control register reached over a plain strobe port.
*/
package cmc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL        = 4'h0;
    localparam logic [3:0]  ADDR_STATUS      = 4'h1;
    localparam logic [3:0]  ADDR_BITDIV      = 4'h2;
    localparam logic [15:0] CTRL_RESET       = 16'h0480;
    localparam logic [15:0] CTRL_WMASK       = 16'h3709;
    localparam int          POS_IDLE_STOP    = 13;
    localparam int          POS_ABORT        = 12;
    localparam int          POS_REQ_LO       = 8;
    localparam int          POS_CUR_LO       = 5;
    localparam int          POS_CAPTURE      = 3;
    localparam int          POS_WINDOW       = 0;
    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_NORMAL      = 3'h0;
    localparam logic [2:0]  MODE_DISABLE     = 3'h1;
    localparam logic [2:0]  MODE_LOOPBACK    = 3'h2;
    localparam logic [2:0]  MODE_LISTEN      = 3'h3;
    localparam logic [2:0]  MODE_CONFIG      = 3'h4;
    localparam logic [2:0]  MODE_LISTEN_ALL  = 3'h7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [3:0]  IDLE_BITS        = 4'hb;
    localparam logic [15:0] BITDIV_RESET     = 16'h0063;
endpackage : cmc_pkg

// ==== cmc_bus_if.sv ====
/*
  interface carrying the bit-time tick and idle detection between modules.
  assumes one clock shared by all users.
*/
`timescale 1ns/100ps
interface cmc_bus_if;
    logic bit_tick;
    logic bus_idle;
    logic rx_level;
    modport det (input bit_tick, input rx_level, output bus_idle);
    modport ctl (output bit_tick, output rx_level, input bus_idle);
endinterface : cmc_bus_if

// ==== cmc_sync.sv ====
/*
  three-stage input synchroniser; a change is taken once stages two and three agree.
  assumes an asynchronous pin input.
*/
`timescale 1ns/100ps
module cmc_sync
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage;

    always_ff @(posedge clk)
    begin
        if (reset)
            stage <= 3'h7;
        else
            stage <= {stage[1:0], din};
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            dout <= 1'b1;
        else if (stage[1] == stage[2])
            dout <= stage[2];
    end
endmodule : cmc_sync

// ==== cmc_idle_det.sv ====
/*
  counts consecutive recessive bits sampled on each bit tick; flags an idle bus.
  assumes bit_tick is a one-cycle pulse per bit time.
*/
`timescale 1ns/100ps
module cmc_idle_det
(
    input  wire logic clk,
    input  wire logic reset,
    cmc_bus_if.det    bus
);
    logic [3:0] run;

    always_ff @(posedge clk)
    begin
        if (reset)
            run <= 4'h0;
        else if (!bus.rx_level)
            run <= 4'h0;
        else if (bus.bit_tick && run != cmc_pkg::IDLE_BITS)
            run <= run + 4'h1;
    end

    assign bus.bus_idle = (run == cmc_pkg::IDLE_BITS);
endmodule : cmc_idle_det

// ==== cmc_asserts.sv ====
/*
  port checker for the can mode control block.
  assumes it is bound onto cmc_top and shares its clock and sync reset.
*/
`timescale 1ns/100ps
module cmc_asserts
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        can_rx,
    input wire logic        device_idle,
    input wire logic        rx_msg_done,
    input wire logic        tx_waiting_idle,
    input wire logic        tx_all_aborted,
    input wire logic        ctl_running,
    input wire logic        abort_req,
    input wire logic        tx_aborted_flag,
    input wire logic        tx_request_clear,
    input wire logic        capture_event,
    input wire logic        filter_window,
    input wire logic [2:0]  mode_out
);
    logic       stop_q;
    logic       cap_q;
    logic       win_q;
    logic [3:0] hi_cnt;
    logic       wr_ctl;
    assign wr_ctl = wr && addr == 4'h0;
    // mirror of the written control bits
    always_ff @(posedge clk)
    begin
        if (reset)
            {stop_q, cap_q, win_q} <= 3'h0;
        else if (wr_ctl)
            {stop_q, cap_q, win_q} <= {wdata[13], wdata[3], wdata[0]};
    end
    // clocks of recessive level in a row
    always_ff @(posedge clk)
    begin
        if (!can_rx)
            hi_cnt <= 4'h0;
        else if (hi_cnt != 4'hf)
            hi_cnt <= hi_cnt + 4'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_halt_idle: assert property (
        ctl_running == !($past(stop_q) && $past(device_idle))) else $error("halt wrong");
    a_abort_set: assert property (
        wr_ctl && wdata[12] |=> abort_req) else $error("abort not set");
    a_abort_done: assert property (
        abort_req && tx_all_aborted && !wr_ctl |-> ##[1:2] !abort_req)
        else $error("abort not cleared");
    a_mode_legal: assert property (
        mode_out != 3'h5 && mode_out != 3'h6) else $error("mode code reserved");
    a_mode_idle: assert property (
        mode_out != $past(mode_out) |-> hi_cnt >= 4'hb) else $error("mode moved on busy bus");
    a_cap_pulse: assert property (
        capture_event == $past(rx_msg_done && cap_q)) else $error("capture wrong");
    a_win_sel: assert property (
        filter_window == win_q) else $error("window wrong");
    a_tx_abort: assert property (
        tx_aborted_flag |-> tx_request_clear && $past(tx_waiting_idle))
        else $error("tx abort wrong");
    a_rsvd_zero: assert property (
        $past(rd) && $past(addr) == 4'h0 |-> (rdata & 16'hc816) == 16'h0000)
        else $error("reserved bits set");
endmodule : cmc_asserts
bind cmc_top cmc_asserts i_cmc_asserts
(
    .clk              (clk),
    .reset            (reset),
    .addr             (addr),
    .wdata            (wdata),
    .wr               (wr),
    .rd               (rd),
    .rdata            (rdata),
    .can_rx           (can_rx),
    .device_idle      (device_idle),
    .rx_msg_done      (rx_msg_done),
    .tx_waiting_idle  (tx_waiting_idle),
    .tx_all_aborted   (tx_all_aborted),
    .ctl_running      (ctl_running),
    .abort_req        (abort_req),
    .tx_aborted_flag  (tx_aborted_flag),
    .tx_request_clear (tx_request_clear),
    .capture_event    (capture_event),
    .filter_window    (filter_window),
    .mode_out         (mode_out)
);

// ==== can_mode_control_bench.sv ====
/*
  self-checking bench for cmc_top.
  assumes the bound checker and a bit divisor of one for short idle times.
*/
`timescale 1ns/100ps
module can_mode_control_bench;
    logic        clk, reset, wr, rd, can_rx, device_idle;
    logic        rx_msg_done, tx_pending, tx_waiting_idle, tx_all_aborted;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic [2:0]  mode_out;
    logic        ctl_running, abort_req, tx_aborted_flag, capture_event, filter_window;
    logic        tx_request_clear;
    int          errors, checks_done;
    logic [2:0]  codes [6] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h0};
    cmc_top i_cmc_top (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .can_rx(can_rx), .device_idle(device_idle),
        .rx_msg_done(rx_msg_done), .tx_pending(tx_pending), .tx_waiting_idle(tx_waiting_idle),
        .tx_all_aborted(tx_all_aborted), .ctl_running(ctl_running), .abort_req(abort_req),
        .tx_aborted_flag(tx_aborted_flag), .tx_request_clear(tx_request_clear),
        .capture_event(capture_event),
        .filter_window(filter_window), .mode_out(mode_out));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (mode_out !== m && n < 300)
        begin
            tick(1);
            n++;
        end
        chk("mode_out", {13'h0, m}, {13'h0, mode_out});
        if (n == 300)
            wrap_up();
    endtask : wait_mode
    task t_regs;
        rd_reg(4'h0);
        chk("ctrl reset", 16'h0480, d);
        wr_reg(4'h0, 16'hc816);
        rd_reg(4'h0);
        chk("ctrl unused", 16'h0080, d);
        rd_reg(4'hf);
        chk("unmapped", 16'h0000, d);
        wr_reg(4'h2, 16'h0001);
        tick(60);
        chk("mode busy", 16'h0004, {13'h0, mode_out});
        @(posedge clk);
        can_rx <= 1'b1;
        wait_mode(3'h0);
    endtask : t_regs
    task t_modes;
        foreach (codes[i])
        begin
            wr_reg(4'h0, {5'h0, codes[i], 8'h00});
            wait_mode(codes[i]);
            rd_reg(4'h0);
            chk("ctrl mode", {5'h0, codes[i], codes[i], 5'h00}, d);
        end
    endtask : t_modes
    task t_stop;
        wr_reg(4'h0, 16'h2001);
        device_idle <= 1'b1;
        tick(3);
        chk("halted", 16'h0000, {15'h0, ctl_running});
        chk("filters", 16'h0001, {15'h0, filter_window});
        wr_reg(4'h0, 16'h0000);
        tick(3);
        chk("running", 16'h0001, {15'h0, ctl_running});
        chk("buffers", 16'h0000, {15'h0, filter_window});
        @(posedge clk);
        device_idle <= 1'b0;
    endtask : t_stop
    task t_abort;
        wr_reg(4'h0, 16'h1000);
        rd_reg(4'h0);
        chk("abort bit", 16'h1000, d);
        chk("abort req", 16'h0001, {15'h0, abort_req});
        @(posedge clk);
        tx_all_aborted <= 1'b1;
        @(posedge clk);
        tx_all_aborted <= 1'b0;
        tick(2);
        chk("abort clear", 16'h0000, {15'h0, abort_req});
    endtask : t_abort
    task t_cap(input logic en);
        wr_reg(4'h0, {12'h0, en, 3'h0});
        @(posedge clk);
        rx_msg_done <= 1'b1;
        @(posedge clk);
        rx_msg_done <= 1'b0;
        #1 chk("capture", {15'h0, en}, {15'h0, capture_event});
    endtask : t_cap
    task t_disable;
        int n;
        @(posedge clk);
        tx_pending <= 1'b1;
        tx_waiting_idle <= 1'b1;
        wr_reg(4'h0, 16'h0100);
        n = 0;
        while (tx_aborted_flag !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        chk("tx aborted", 16'h0001, {15'h0, tx_aborted_flag});
        chk("tx req clear", 16'h0001, {15'h0, tx_request_clear});
        if (n == 200)
            wrap_up();
        @(posedge clk);
        tx_pending <= 1'b0;
        tx_waiting_idle <= 1'b0;
        wait_mode(3'h1);
        rd_reg(4'h1);
        chk("status set", 16'h0003, d);
        wr_reg(4'h1, 16'h0001);
        rd_reg(4'h1);
        chk("status clear", 16'h0002, d);
    endtask : t_disable
    initial
    begin
        {reset, wr, rd, can_rx, device_idle} = 5'h10;
        {rx_msg_done, tx_pending, tx_waiting_idle, tx_all_aborted} = 4'h0;
        addr = 4'h0;
        wdata = 16'h0000;
        errors = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_modes;
        t_stop;
        t_abort;
        t_cap(1'b1);
        t_cap(1'b0);
        t_disable;
        wrap_up;
    end
endmodule : can_mode_control_bench
